// *** hdl/irw_encoder.sv ***
// infrared remote command word encoder: burst, start bit, six biphase data bits, repeat and end marker
// assumes channel codes arrive with valid/ready and key_held is high while the key stays down
`timescale 1ns/1ps
module irw_encoder import irw_pkg::*; #(
  parameter int REPEAT_CYCLES = REPEAT_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // key events
  input wire logic key_valid,
  output logic key_ready,
  input wire logic [CODE_W-1:0] key_code,
  input wire logic key_held,
  // emitter drive and status
  output logic ir_drive,
  output logic tx_busy,
  output logic word_done,
  output logic code_dropped
);
  irw_state_t state_r;
  irw_state_t state_nxt;
  logic [SEG_W-1:0] seg_cnt_r;
  logic [REP_W-1:0] rep_cnt_r;
  logic [CAR_W-1:0] car_cnt_r;
  logic [2:0] bit_idx_r;
  logic [WORD_BITS-1:0] shift_r;
  logic [CODE_W-1:0] code_r;
  logic eot_r;
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_ready;
  logic [CODE_W-1:0] fifo_code;
  logic seg_end;
  logic rep_end;
  logic start_new;
  logic resend;
  logic send_eot;
  logic env;

  irw_fifo #(
    .WIDTH(CODE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(key_valid),
    .in_ready(fifo_ready),
    .in_data(key_code),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_code)
  );

  assign key_ready = fifo_ready;

  // a code is taken from the fifo only while idle, so a held key stalls later codes
  assign fifo_pop = (state_r == ST_IDLE) && fifo_valid;
  assign start_new = fifo_pop && (fifo_code != CODE_RSVD);
  assign rep_end = (rep_cnt_r == REP_W'(REPEAT_CYCLES - 1));
  assign resend = (state_r == ST_HOLD) && rep_end && !eot_r && key_held;
  assign send_eot = (state_r == ST_HOLD) && rep_end && !eot_r && !key_held;

  always_comb begin
    unique case (state_r)
      ST_BURST: seg_end = (seg_cnt_r == SEG_W'(BURST_CYC - 1));
      ST_GAP, ST_BITS: seg_end = (seg_cnt_r == SEG_W'(BIT_CYC - 1));
      default: seg_end = 1'b0;
    endcase
  end

  // word sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start_new) begin
          state_nxt = ST_BURST;
        end
      end
      ST_BURST: begin
        if (seg_end) begin
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        if (seg_end) begin
          state_nxt = ST_BITS;
        end
      end
      ST_BITS: begin
        if (seg_end && bit_idx_r == 3'(WORD_BITS - 1)) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // the word slot is the whole repeat interval, which keeps the emitter near 0.03 percent duty
        if (rep_end) begin
          state_nxt = eot_r ? ST_IDLE : ST_BURST;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // position inside the current segment
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      seg_cnt_r <= '0;
    end else if (state_nxt != state_r || seg_end || state_r == ST_IDLE || state_r == ST_HOLD) begin
      seg_cnt_r <= '0;
    end else begin
      seg_cnt_r <= seg_cnt_r + 1'b1;
    end
  end

  // repeat interval, measured from the start of each burst
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rep_cnt_r <= '0;
    end else if (state_nxt == ST_BURST && state_r != ST_BURST) begin
      rep_cnt_r <= '0;
    end else if (state_r != ST_IDLE && !rep_end) begin
      rep_cnt_r <= rep_cnt_r + 1'b1;
    end
  end

  // code held for repeats, end marker after release
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      code_r <= '0;
      eot_r <= 1'b0;
    end else if (start_new) begin
      code_r <= fifo_code;
      eot_r <= 1'b0;
    end else if (send_eot) begin
      code_r <= CODE_EOT;
      eot_r <= 1'b1;
    end
  end

  // start bit then data msb first; the start bit is always a one
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_r <= '0;
      bit_idx_r <= '0;
    end else if (start_new) begin
      shift_r <= {1'b1, fifo_code};
      bit_idx_r <= '0;
    end else if (resend) begin
      shift_r <= {1'b1, code_r};
      bit_idx_r <= '0;
    end else if (send_eot) begin
      shift_r <= {1'b1, CODE_EOT};
      bit_idx_r <= '0;
    end else if (state_r == ST_BITS && seg_end) begin
      shift_r <= {shift_r[WORD_BITS-2:0], 1'b0};
      bit_idx_r <= bit_idx_r + 1'b1;
    end
  end

  // carrier divider restarts with every word so each burst opens with a full carrier cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      car_cnt_r <= '0;
    end else if (state_r == ST_IDLE || state_r == ST_HOLD) begin
      car_cnt_r <= '0;
    end else begin
      car_cnt_r <= car_cnt_r + 1'b1;
    end
  end

  // envelope: burst on, gap off, biphase carrier in the first half for a one, second half for a zero
  always_comb begin
    unique case (state_r)
      ST_BURST: env = 1'b1;
      ST_BITS: env = shift_r[WORD_BITS-1] ? (seg_cnt_r < SEG_W'(HALF_CYC)) : (seg_cnt_r >= SEG_W'(HALF_CYC));
      default: env = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ir_drive <= 1'b0;
    end else begin
      ir_drive <= env && !car_cnt_r[CAR_W-1];
    end
  end

  // status outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_busy <= 1'b0;
      word_done <= 1'b0;
      code_dropped <= 1'b0;
    end else begin
      tx_busy <= (state_nxt != ST_IDLE);
      word_done <= (state_r == ST_BITS) && (state_nxt == ST_HOLD);
      code_dropped <= fifo_pop && (fifo_code == CODE_RSVD);
    end
  end
endmodule // irw_encoder

// *** include/irw_pkg.sv ***
// constants for the infrared remote command word encoder
// assumes one clock, mclk, which stands in for the transmitter oscillator
//
// Summary of operation
// - each word is a gain-setting burst, then a start bit, then exactly six data bits with the channel code.
// - the six data bits carry the channel number 0 to 62 as plain binary.
// - the all-ones channel code is reserved and is never transmitted.
// - the carrier is the oscillator clock divided by sixteen.
// - one bit lasts thirty-two carrier cycles, that is 512 oscillator cycles.
// - the emitter duty cycle stays near 0.03 percent through the spacing between repeated words.
// - the burst lasts 256 oscillator cycles and the start bit begins one bit period after it.
// - a data one has carrier right after the bit boundary, a zero has none there.
// - while a key stays pressed the same word is resent every 90 ms.
// - on key release one word with channel 62 is sent to mark end of transmission.
package irw_pkg;
  localparam int CODE_W = 6;
  localparam logic [5:0] CODE_RSVD = 6'h3f;
  localparam logic [5:0] CODE_EOT = 6'h3e;
  localparam int WORD_BITS = 7;
  localparam int CAR_DIV = 16;
  localparam int CAR_W = 4;
  localparam int BIT_CYC = 512;
  localparam int HALF_CYC = BIT_CYC / 2;
  localparam int BURST_CYC = 256;
  localparam int SEG_W = 9;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_HZ = 40_000_000;
  localparam int REPEAT_MS = 90;
  localparam int REPEAT_CYC = (CLK_HZ / 1000) * REPEAT_MS;
  localparam int REP_W = 22;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_BURST = 5'h02,
    ST_GAP = 5'h04,
    ST_BITS = 5'h08,
    ST_HOLD = 5'h10
  } irw_state_t;
endpackage

// *** hdl/irw_fifo.sv ***
// small synchronous fifo holding channel codes ahead of the encoder
// assumes one clock and an asynchronous active high reset
`timescale 1ns/1ps
module irw_fifo import irw_pkg::*; #(
  parameter int WIDTH = CODE_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_r];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  // ready and valid are registered so the top can drive key_ready straight from a flop
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      unique case ({push, pop})
        2'b10: begin
          count_r <= count_r + 1'b1;
          in_ready <= (count_r != (AW+1)'(DEPTH - 1));
          out_valid <= 1'b1;
        end
        2'b01: begin
          count_r <= count_r - 1'b1;
          in_ready <= 1'b1;
          out_valid <= (count_r != (AW+1)'(1));
        end
        default: begin
          in_ready <= (count_r != (AW+1)'(DEPTH));
          out_valid <= (count_r != '0);
        end
      endcase
    end
  end
endmodule // irw_fifo

// *** tb/irw_asserts.sv ***
// checker for the encoder: carrier, word framing and slot spacing
// assumes it is bound to irw_encoder and sees only its ports
`timescale 1ns/1ps
module irw_asserts import irw_pkg::*; #(
  parameter int REPEAT_CYCLES = REPEAT_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // key side
  input wire logic key_valid,
  input wire logic key_ready,
  input wire logic [CODE_W-1:0] key_code,
  input wire logic key_held,
  // emitter side
  input wire logic ir_drive,
  input wire logic tx_busy,
  input wire logic word_done,
  input wire logic code_dropped
);
  int dk;
  int wt;
  logic bs;
  // in-word dark spans stay under 600, gaps between words exceed it
  assign bs = ir_drive && dk > 600;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) dk <= 1000;
    else if (ir_drive) dk <= 0;
    else if (dk < 1000) dk <= dk + 1;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    // cap at one slot so a long idle still satisfies the spacing check for any interval setting
    if (sys_rst) wt <= REPEAT_CYCLES;
    else if (bs) wt <= 1;
    else if (wt < REPEAT_CYCLES) wt <= wt + 1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_carrier_div: assert property ($rose(ir_drive) |-> ir_drive[*8] ##1 !ir_drive[*8])
    else $error("carrier not mclk/16");
  a_burst_len: assert property (wt == 247 |-> ir_drive ##1 !ir_drive)
    else $error("burst length wrong");
  a_start_gap: assert property (wt == 768 |-> ir_drive && dk == 520)
    else $error("start bit misplaced");
  a_biphase_cell: assert property (wt >= 1024 && wt <= 4096 && wt % 512 == 0 |-> ir_drive != $past(ir_drive, 256))
    else $error("cell not biphase");
  a_done_time: assert property (word_done |-> wt == 4351 ##1 !word_done)
    else $error("word_done misplaced");
  a_slot_space: assert property (bs |-> wt >= REPEAT_CYCLES)
    else $error("words too close");
  a_slot_dark: assert property (wt > 4352 && wt < REPEAT_CYCLES |-> !ir_drive)
    else $error("drive after word");
  a_idle_dark: assert property (!tx_busy |-> !ir_drive)
    else $error("drive while idle");
  a_drop_dark: assert property (code_dropped |-> !tx_busy && !ir_drive)
    else $error("reserved code sent");
endmodule // irw_asserts
bind irw_encoder irw_asserts #(.REPEAT_CYCLES(REPEAT_CYCLES)) u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .key_valid(key_valid), .key_ready(key_ready), .key_code(key_code), .key_held(key_held),
  .ir_drive(ir_drive), .tx_busy(tx_busy), .word_done(word_done), .code_dropped(code_dropped));

// *** tb/irw_rx_model.sv ***
// receiver model: detector output and recovery of start and data bits
// assumes ir_drive carries mclk/16 carrier in bursts
`timescale 1ns/1ps
module irw_rx_model (
  // clock
  input wire logic mclk,
  // light from the emitter
  input wire logic ir_drive,
  // detector and recovered word
  output logic det_n,
  output logic rx_valid,
  output logic [6:0] rx_word
);
  int since = 100;
  int idle = 1000;
  int t = 100000;
  assign det_n = since >= 16;
  always @(posedge mclk) begin
    // an unknown drive before reset counts as dark so no false burst is seen
    since <= (ir_drive === 1'b1) ? 0 : since + 1;
    idle <= det_n ? idle + 1 : 0;
    t <= (!det_n && idle > 600) ? 1 : t + 1;
    rx_valid <= 1'b0;
    // sample a quarter into each cell, timed from the burst
    if (t >= 896 && t <= 3968 && (t - 896) % 512 == 0) rx_word <= {rx_word[5:0], !det_n};
    if (t == 3969) rx_valid <= 1'b1;
  end
endmodule // irw_rx_model

// *** tb/irw_encoder_tb.sv ***
// bench for the encoder: fifo fill, repeat, end marker, reserved code
// assumes the checker is bound to the encoder
`timescale 1ns/1ps
module irw_encoder_tb import irw_pkg::*;;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic key_valid = 1'b0;
  logic [5:0] key_code = 6'h00;
  logic key_held = 1'b0;
  logic key_ready, ir_drive, tx_busy, word_done, code_dropped, det_n, rx_valid;
  logic [6:0] rx_word;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int last = 0;
  int drops = 0;
  int acc = 0;
  logic [5:0] tbl [10] = '{6'h0a, 6'h3f, 6'h00, 6'h3e, 6'h15, 6'h2a, 6'h01, 6'h3d, 6'h33, 6'h07};
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (code_dropped === 1'b1) drops <= drops + 1;
  end
  irw_encoder #(.REPEAT_CYCLES(5000)) u_dut (.mclk(mclk), .sys_rst(sys_rst), .key_valid(key_valid),
    .key_ready(key_ready), .key_code(key_code), .key_held(key_held), .ir_drive(ir_drive),
    .tx_busy(tx_busy), .word_done(word_done), .code_dropped(code_dropped));
  irw_rx_model u_rx (.mclk(mclk), .ir_drive(ir_drive), .det_n(det_n), .rx_valid(rx_valid), .rx_word(rx_word));
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask
  // gap of zero skips the spacing check
  task automatic getw(input logic [5:0] c, input int gap);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 12000) begin
      @(negedge mclk);
      n++;
    end
    chk(n < 12000, "no word");
    chk(rx_word === {1'b1, c}, "wrong word");
    if (gap > 0) chk(cyc - last == gap, "wrong spacing");
    last = cyc;
    @(negedge mclk);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_reset;
    repeat (5) @(negedge mclk);
    chk({key_ready, ir_drive, tx_busy, word_done, code_dropped} === 5'h00, "outputs set in reset");
    sys_rst = 1'b0;
    @(negedge mclk);
    chk(key_ready === 1'b1, "not ready");
  endtask
  // fill while the first word repeats, then release for the end marker
  task automatic t_fill;
    key_held = 1'b1;
    for (int i = 0; i < 10; i++) begin
      key_valid = key_ready === 1'b1 && acc == i;
      key_code = tbl[i];
      if (key_valid) acc++;
      @(negedge mclk);
    end
    key_valid = 1'b0;
    chk(acc == 9, "fifo depth");
    getw(6'h0a, 0);
    getw(6'h0a, 5000);
    key_held = 1'b0;
    getw(6'h3e, 5000);
  endtask
  task automatic t_drain;
    for (int i = 1; i < 9; i++) begin
      if (tbl[i] != 6'h3f) begin
        getw(tbl[i], 0);
        getw(6'h3e, 5000);
      end
    end
    // the end marker slot closes about 1030 cycles after its word is received
    repeat (1100) @(negedge mclk);
    chk(drops == 1, "reserved code not dropped");
    chk(key_ready === 1'b1 && tx_busy === 1'b0 && ir_drive === 1'b0, "not idle");
  endtask
  initial begin
    t_reset();
    t_fill();
    t_drain();
    test_done();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    $display("ERROR at %0t: watchdog", $time);
    test_done();
  end
endmodule // irw_encoder_tb
